// ===== rtl/rcs_pkg.sv
package rcs_pkg;
  // Register byte addresses.
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_STACK = 8'h04;
  localparam logic [7:0] REG_TOS = 8'h08;
  localparam logic [7:0] REG_PC = 8'h0C;
  localparam logic [7:0] REG_PCLAT = 8'h10;
  localparam logic [7:0] REG_TBLPTR = 8'h14;
  localparam logic [7:0] REG_TBLAT = 8'h18;
  localparam logic [7:0] REG_INTC = 8'h1C;
  localparam logic [7:0] REG_PROD = 8'h20;
  localparam logic [7:0] REG_WORK = 8'h24;
  localparam logic [7:0] REG_PORT_A_PINS = 8'h28;
  localparam logic [7:0] REG_CFG = 8'h2C;
  // Status register fields and layout.
  localparam int BIT_INTERRUPT_PRIORITY_ENABLE = 7;
  localparam int BIT_RI = 4;
  localparam int BIT_TO = 3;
  localparam int BIT_PD = 2;
  localparam int BIT_POR = 1;
  localparam int BIT_BOR = 0;
  localparam logic [7:0] STATUS_RST = 8'h1F;
  localparam logic [7:0] STATUS_IMPL = 8'h9F;
  localparam logic [7:0] STATUS_WMASK = 8'h93;
  // Return stack pointer fields.
  localparam int BIT_STKFULL = 7;
  localparam int BIT_STACK_UNDERFLOW_FLAG = 6;
  localparam logic [7:0] STACK_WMASK = 8'hDF;
  // Interrupt control reset patterns and implemented bits.
  localparam int BIT_HIGH_PRIORITY_GLOBAL_ENABLE = 7;
  localparam int BIT_LOW_PRIORITY_GLOBAL_ENABLE = 6;
  localparam logic [7:0] INTC_B_RST = 8'hF5;
  localparam logic [7:0] INTC_B_IMPL = 8'hF5;
  localparam logic [7:0] INTC_C_RST = 8'hC0;
  localparam logic [7:0] INTC_C_IMPL = 8'hDB;
  // Program addresses.
  localparam logic [20:0] VEC_HIGH = 21'h000008;
  localparam logic [20:0] VEC_LOW = 21'h000018;
  localparam logic [20:0] PC_STEP = 21'h000002;
  localparam logic [7:0] PORT_A_PINS_OSC_MASK = 8'h3F;
  // Configuration register reset value.
  localparam logic [1:0] CFG_RST = 2'h3;
  // Power modes reported by the core.
  localparam logic [1:0] PM_FULL = 2'h0;
  localparam logic [1:0] PM_RUN = 2'h1;
  localparam logic [1:0] PM_IDLE = 2'h2;
  typedef enum logic [3:0] {
    EV_NONE, EV_POR, EV_BOR, EV_MASTER_CLEAR_PIN_FULL, EV_MASTER_CLEAR_PIN_RUN, EV_MASTER_CLEAR_PIN_IDLE,
    EV_WDT_RST, EV_RESET_INS, EV_STK_FULL, EV_STK_UNF_RST,
    EV_STK_UNF_ERR, EV_WDT_WAKE, EV_INT_WAKE
  } rcs_evt_t;
endpackage

// ===== rtl/rcs_reset_status.sv
`timescale 1ns/1ps
// Summary of operation
// - Status bit 7 priority enable, bits 6:5 zero, bits 4:0 cause flags.
// - Time-out and power-down flags read-only; all five flags read 1 at start.
// - Power-on sets RI,TO,PD, clears POR,BOR and stack flags; brown-out sets RI,TO,PD and clears BOR only.
// - Reset instruction restarts at zero and clears only RI.
// - Master clear in run mode restarts at zero and sets TO.
// - Master clear in idle or sleep sets TO and clears PD.
// - Watchdog reset in full power or run mode clears TO.
// - Master clear at full power changes no flag.
// - With stack reset enabled, overflow resets and sets stack full.
// - With stack reset enabled, underflow resets and sets stack underflow.
// - With stack reset disabled, underflow only sets its flag.
// - Watchdog in idle or sleep wakes at PC+2, clearing TO and PD.
// - Interrupt wake continues at PC+2 and clears PD only.
// - Interrupt wake with global enable loads the high or low vector.
// - Such wake pushes PC to top of stack and advances the pointer.
// - Every reset zeroes top of stack and pointer count bits.
// - Resets clear PC latches, PC low byte, table pointer and latch.
// - Resets load interrupt control patterns; interrupt wake sets interrupt flags.
// - Product and accumulator registers keep values on events.
// - Port A bits 7:6 exist only when the oscillator frees them.
// - Master clear pin is input only and may be disabled.
// - Wake-ups update cause flags and the restart PC; interrupt wake also updates interrupt flags and, with global enable, the stack; other registers keep values.
module rcs_reset_status
  import rcs_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [7:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  input wire logic por_i,
  input wire logic bor_i,
  input wire logic master_clear_pin_n_i,
  input wire logic wdt_timeout_i,
  input wire logic reset_instr_i,
  input wire logic stack_overflow_i,
  input wire logic stack_underflow_i,
  input wire logic int_wake_i,
  input wire logic int_wake_high_i,
  input wire logic [7:0] int_wake_flags_i,
  input wire logic [1:0] power_mode_i,
  input wire logic [20:0] core_pc_i,
  input wire logic osc_frees_pins_i,
  input wire logic [7:0] port_a_pins_i,
  output logic core_restart_o,
  output logic [20:0] restart_pc_o,
  output logic [7:0] port_a_latch_o,
  output logic [7:0] port_a_direction_o
);

  function automatic logic [7:0] merge8(input logic [7:0] old,
                                        input logic [7:0] nw,
                                        input logic [7:0] mask);
    merge8 = (old & ~mask) | (nw & mask);
  endfunction

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic master_clear_pin_s1_ff, master_clear_pin_s2_ff, master_clear_pin_s3_ff;
  logic [7:0] pins_s1_ff, pins_s2_ff;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      master_clear_pin_s1_ff <= 1'b1;
      master_clear_pin_s2_ff <= 1'b1;
      master_clear_pin_s3_ff <= 1'b1;
      pins_s1_ff <= 8'h00;
      pins_s2_ff <= 8'h00;
    end else begin
      master_clear_pin_s1_ff <= master_clear_pin_n_i;
      master_clear_pin_s2_ff <= master_clear_pin_s1_ff;
      master_clear_pin_s3_ff <= master_clear_pin_s2_ff;
      pins_s1_ff <= port_a_pins_i;
      pins_s2_ff <= pins_s1_ff;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [7:0] status_ff, stack_ff;
  logic [20:0] tos_ff, restart_pc_ff;
  logic [12:0] pclat_ff;
  logic [21:0] tblptr_ff;
  logic [7:0] tblat_ff, intc_a_ff, intc_b_ff, intc_c_ff;
  logic [15:0] prod_ff;
  logic [19:0] work_ff;
  logic [7:0] lat_ff, dir_ff;
  logic [1:0] cfg_ff;
  logic restart_ff, ack_ff;
  logic [31:0] rdata_ff;
  logic stk_reset_en, master_clear_pin_en, master_clear_pin_fall, any_reset, gie_wake;
  logic wr_go;
  rcs_evt_t ev;

  assign stk_reset_en = cfg_ff[0];
  assign master_clear_pin_en = cfg_ff[1];
  // The pin is only ever sampled; no internal reset drives it.
  assign master_clear_pin_fall = master_clear_pin_en & master_clear_pin_s3_ff & ~master_clear_pin_s2_ff;

  // ---------------------------------------------------------------
  // Event decode, highest priority first
  // ---------------------------------------------------------------
  always_comb begin
    ev = EV_NONE;
    if (por_i) begin
      ev = EV_POR;
    end else if (bor_i) begin
      ev = EV_BOR;
    end else if (master_clear_pin_fall) begin
      if (power_mode_i == PM_IDLE) begin
        ev = EV_MASTER_CLEAR_PIN_IDLE;
      end else if (power_mode_i == PM_RUN) begin
        ev = EV_MASTER_CLEAR_PIN_RUN;
      end else begin
        ev = EV_MASTER_CLEAR_PIN_FULL;
      end
    end else if (wdt_timeout_i) begin
      ev = (power_mode_i == PM_IDLE) ? EV_WDT_WAKE : EV_WDT_RST;
    end else if (reset_instr_i) begin
      ev = EV_RESET_INS;
    end else if (stack_overflow_i && stk_reset_en) begin
      ev = EV_STK_FULL;
    end else if (stack_underflow_i) begin
      ev = stk_reset_en ? EV_STK_UNF_RST : EV_STK_UNF_ERR;
    end else if (int_wake_i && power_mode_i != PM_FULL) begin
      ev = EV_INT_WAKE;
    end
  end

  always_comb begin
    case (ev)
      EV_POR, EV_BOR, EV_MASTER_CLEAR_PIN_FULL, EV_MASTER_CLEAR_PIN_RUN, EV_MASTER_CLEAR_PIN_IDLE,
      EV_WDT_RST, EV_RESET_INS, EV_STK_FULL, EV_STK_UNF_RST: begin
        any_reset = 1'b1;
      end
      default: begin
        any_reset = 1'b0;
      end
    endcase
  end

  assign gie_wake = (ev == EV_INT_WAKE) &&
    (int_wake_high_i ? intc_a_ff[BIT_HIGH_PRIORITY_GLOBAL_ENABLE] : intc_a_ff[BIT_LOW_PRIORITY_GLOBAL_ENABLE]);

  // ---------------------------------------------------------------
  // Avalon-MM slave: one wait cycle, then answer
  // ---------------------------------------------------------------
  assign waitrequest_o = (read_i | write_i) & ~ack_ff;
  assign wr_go = write_i & ack_ff;
  assign readdata_o = rdata_ff;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= (read_i | write_i) & ~ack_ff;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_ff <= 32'h0000_0000;
    end else if (read_i && !ack_ff) begin
      case (address_i)
        REG_STATUS: rdata_ff <= {24'h0, status_ff & STATUS_IMPL};
        REG_STACK: rdata_ff <= {24'h0, stack_ff};
        REG_TOS: rdata_ff <= {11'h0, tos_ff};
        REG_PC: rdata_ff <= {11'h0, restart_pc_ff};
        REG_PCLAT: rdata_ff <= {19'h0, pclat_ff};
        REG_TBLPTR: rdata_ff <= {10'h0, tblptr_ff};
        REG_TBLAT: rdata_ff <= {24'h0, tblat_ff};
        REG_INTC: rdata_ff <= {8'h0, intc_c_ff, intc_b_ff, intc_a_ff};
        REG_PROD: rdata_ff <= {16'h0, prod_ff};
        REG_WORK: rdata_ff <= {12'h0, work_ff};
        REG_PORT_A_PINS: rdata_ff <= {8'h0, pins_s2_ff & port_a_direction_o,
                                port_a_direction_o, port_a_latch_o};
        REG_CFG: rdata_ff <= {30'h0, cfg_ff};
        default: rdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Cause flags; an event in the write cycle wins over the write
  // ---------------------------------------------------------------
  logic [7:0] nxt_status;
  always_comb begin
    nxt_status = status_ff;
    if (wr_go && address_i == REG_STATUS) begin
      nxt_status = merge8(status_ff, writedata_i[7:0], STATUS_WMASK);
    end
    case (ev)
      EV_POR: begin
        nxt_status[4:0] = 5'h1C;
      end
      EV_BOR: begin
        nxt_status[4:2] = 3'h7;
        nxt_status[BIT_BOR] = 1'b0;
      end
      EV_RESET_INS: nxt_status[BIT_RI] = 1'b0;
      EV_MASTER_CLEAR_PIN_RUN: nxt_status[BIT_TO] = 1'b1;
      EV_MASTER_CLEAR_PIN_IDLE: begin
        nxt_status[BIT_TO] = 1'b1;
        nxt_status[BIT_PD] = 1'b0;
      end
      EV_WDT_RST: nxt_status[BIT_TO] = 1'b0;
      EV_WDT_WAKE: begin
        nxt_status[BIT_TO] = 1'b0;
        nxt_status[BIT_PD] = 1'b0;
      end
      EV_INT_WAKE: nxt_status[BIT_PD] = 1'b0;
      default: begin
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      status_ff <= STATUS_RST;
    end else begin
      status_ff <= nxt_status & STATUS_IMPL;
    end
  end

  // ---------------------------------------------------------------
  // Return stack pointer and top of stack
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      stack_ff <= 8'h00;
      tos_ff <= 21'h0;
    end else begin
      if (wr_go && address_i == REG_STACK) begin
        stack_ff <= merge8(stack_ff, writedata_i[7:0], STACK_WMASK);
      end
      if (wr_go && address_i == REG_TOS) begin
        tos_ff <= writedata_i[20:0];
      end
      if (any_reset) begin
        tos_ff <= 21'h0;
        stack_ff[4:0] <= 5'h00;
        stack_ff[5] <= 1'b0;
      end
      case (ev)
        EV_POR: begin
          stack_ff[BIT_STKFULL] <= 1'b0;
          stack_ff[BIT_STACK_UNDERFLOW_FLAG] <= 1'b0;
        end
        EV_STK_FULL: stack_ff[BIT_STKFULL] <= 1'b1;
        EV_STK_UNF_RST, EV_STK_UNF_ERR: begin
          stack_ff[BIT_STACK_UNDERFLOW_FLAG] <= 1'b1;
        end
        EV_INT_WAKE: begin
          if (gie_wake) begin
            tos_ff <= core_pc_i;
            stack_ff[4:0] <= stack_ff[4:0] + 5'h01;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Restart address toward the core
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      restart_ff <= 1'b0;
      restart_pc_ff <= 21'h0;
    end else begin
      restart_ff <= any_reset || ev == EV_WDT_WAKE || ev == EV_INT_WAKE;
      if (any_reset) begin
        restart_pc_ff <= 21'h0;
      end else if (gie_wake) begin
        restart_pc_ff <= int_wake_high_i ? VEC_HIGH : VEC_LOW;
      end else if (ev == EV_WDT_WAKE || ev == EV_INT_WAKE) begin
        restart_pc_ff <= core_pc_i + PC_STEP;
      end
    end
  end

  assign core_restart_o = restart_ff;
  assign restart_pc_o = restart_pc_ff;

  // ---------------------------------------------------------------
  // PC latches, table pointer and table latch
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i || any_reset) begin
      pclat_ff <= 13'h0;
      tblptr_ff <= 22'h0;
      tblat_ff <= 8'h00;
    end else if (wr_go) begin
      if (address_i == REG_PCLAT) begin
        pclat_ff <= writedata_i[12:0];
      end
      if (address_i == REG_TBLPTR) begin
        tblptr_ff <= writedata_i[21:0];
      end
      if (address_i == REG_TBLAT) begin
        tblat_ff <= writedata_i[7:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Interrupt control registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      intc_a_ff <= 8'h00;
      intc_b_ff <= INTC_B_RST;
      intc_c_ff <= INTC_C_RST;
    end else if (any_reset) begin
      intc_a_ff <= {7'h00, intc_a_ff[0]};
      intc_b_ff <= INTC_B_RST;
      intc_c_ff <= INTC_C_RST;
    end else begin
      if (wr_go && address_i == REG_INTC) begin
        intc_a_ff <= writedata_i[7:0];
        intc_b_ff <= writedata_i[15:8] & INTC_B_IMPL;
        intc_c_ff <= writedata_i[23:16] & INTC_C_IMPL;
      end
      if (ev == EV_INT_WAKE) begin
        intc_a_ff <= intc_a_ff | int_wake_flags_i;
      end
    end
  end

  // ---------------------------------------------------------------
  // Data registers untouched by reset events
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      prod_ff <= 16'h0000;
      work_ff <= 20'h0_0000;
    end else if (wr_go) begin
      if (address_i == REG_PROD) begin
        prod_ff <= writedata_i[15:0];
      end
      if (address_i == REG_WORK) begin
        work_ff <= writedata_i[19:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Port A latch and direction, configuration
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      lat_ff <= 8'h00;
      dir_ff <= 8'h00;
      cfg_ff <= CFG_RST;
    end else if (wr_go) begin
      if (address_i == REG_PORT_A_PINS) begin
        lat_ff <= writedata_i[7:0];
        dir_ff <= writedata_i[15:8];
      end
      if (address_i == REG_CFG) begin
        cfg_ff <= writedata_i[1:0];
      end
    end
  end

  // Upper pins vanish while the oscillator owns them.
  assign port_a_latch_o =
    lat_ff & (osc_frees_pins_i ? 8'hFF : PORT_A_PINS_OSC_MASK);
  assign port_a_direction_o =
    dir_ff & (osc_frees_pins_i ? 8'hFF : PORT_A_PINS_OSC_MASK);

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  por_flags_a: assert property (
    ev == EV_POR |=> status_ff[4:0] == 5'h1C && stack_ff[7:6] == 2'h0)
    else $error("power-on flags wrong");
  rinst_flag_a: assert property (
    ev == EV_RESET_INS |=> !status_ff[BIT_RI] && restart_pc_o == 21'h0
      && $stable(status_ff[3:0]))
    else $error("reset instruction flags wrong");
  master_clear_pin_idle_a: assert property (
    ev == EV_MASTER_CLEAR_PIN_IDLE |=> status_ff[BIT_TO] && !status_ff[BIT_PD])
    else $error("master clear idle flags wrong");
  wdt_wake_pc_a: assert property (
    ev == EV_WDT_WAKE |=> core_restart_o
      && restart_pc_o == $past(core_pc_i) + PC_STEP
      && status_ff[3:2] == 2'b00)
    else $error("watchdog wake wrong");
  vector_load_a: assert property (
    gie_wake && int_wake_high_i |=> restart_pc_o == VEC_HIGH)
    else $error("high vector not loaded");
  stack_push_a: assert property (
    gie_wake |=> tos_ff == $past(core_pc_i)
      && stack_ff[4:0] == $past(stack_ff[4:0]) + 5'h01)
    else $error("wake push wrong");
  unf_error_a: assert property (
    ev == EV_STK_UNF_ERR |=> !core_restart_o && stack_ff[BIT_STACK_UNDERFLOW_FLAG]
      && $stable(status_ff))
    else $error("underflow error misbehaved");
  table_clear_a: assert property (
    any_reset |=> tblptr_ff == 22'h0 && tblat_ff == 8'h00
      && pclat_ff == 13'h0 && tos_ff == 21'h0)
    else $error("reset did not clear pointers");
  port_a_pins_mask_a: assert property (
    !osc_frees_pins_i |-> port_a_latch_o[7:6] == 2'b00
      && port_a_direction_o[7:6] == 2'b00)
    else $error("port a upper bits visible");
  one_wait_a: assert property (
    (read_i || write_i) && waitrequest_o |=> !waitrequest_o)
    else $error("bus answer late");

  por_seen_c: cover property (ev == EV_POR);
  int_vec_c: cover property (gie_wake ##1 core_restart_o);
  stk_full_c: cover property (ev == EV_STK_FULL);
  wr_clash_c: cover property (wr_go && address_i == REG_STATUS
    && ev != EV_NONE);

endmodule

// ===== verif/tb.sv
`timescale 1ns/1ps
module tb
  import rcs_pkg::*;
;
  typedef struct {
    int k;
    logic [1:0] pm;
    logic rst;
    logic [20:0] pc;
    logic [7:0] st;
    logic [7:0] stk;
  } rcs_row_t;
  localparam logic [20:0] CORE_PC = 21'h001234;
  localparam logic [20:0] WAKE_PC = CORE_PC + PC_STEP;
  localparam logic [7:0] WAKE_FLAGS = 8'h04;
  localparam int K_POR = 0, K_BOR = 1, K_MASTER_CLEAR_PIN = 2, K_WDT = 3;
  localparam int K_RI = 4, K_OVF = 5, K_UNF = 6, K_INT = 7;

  logic clk_i, srst_i, read_i, write_i, waitrequest_o, core_restart_o;
  logic [7:0] address_i;
  logic [31:0] writedata_i, readdata_o;
  logic por_i, bor_i, master_clear_pin_n_i, wdt_timeout_i, reset_instr_i;
  logic stack_overflow_i, stack_underflow_i, int_wake_i, int_wake_high_i;
  logic [7:0] int_wake_flags_i, port_a_pins_i;
  logic [7:0] port_a_latch_o, port_a_direction_o;
  logic [1:0] power_mode_i;
  logic [20:0] core_pc_i, restart_pc_o, got_pc;
  logic osc_frees_pins_i;
  int fails = 0;
  int total_checks = 0;
  int cycles = 0;
  int got_n;
  rcs_row_t rows [15];

  rcs_reset_status i_rcs_reset_status (
    .clk_i(clk_i), .srst_i(srst_i), .address_i(address_i),
    .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
    .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
    .por_i(por_i), .bor_i(bor_i),
    .master_clear_pin_n_i(master_clear_pin_n_i),
    .wdt_timeout_i(wdt_timeout_i), .reset_instr_i(reset_instr_i),
    .stack_overflow_i(stack_overflow_i),
    .stack_underflow_i(stack_underflow_i), .int_wake_i(int_wake_i),
    .int_wake_high_i(int_wake_high_i),
    .int_wake_flags_i(int_wake_flags_i), .power_mode_i(power_mode_i),
    .core_pc_i(core_pc_i), .osc_frees_pins_i(osc_frees_pins_i),
    .port_a_pins_i(port_a_pins_i), .core_restart_o(core_restart_o),
    .restart_pc_o(restart_pc_o), .port_a_latch_o(port_a_latch_o),
    .port_a_direction_o(port_a_direction_o)
  );

  initial begin
    clk_i = 1'h0;
    forever #5 clk_i = ~clk_i;
  end

  // The run is a few hundred cycles; a hang is cut short here.
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails++;
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic summarize;
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Entered just after a rising edge; holds the request until the edge
  // at which waitrequest is seen low, then leaves one idle edge.
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] d);
    int n;
    n = 0;
    address_i <= a;
    writedata_i <= wd;
    read_i <= ~wr;
    write_i <= wr;
    @(posedge clk_i);
    while (waitrequest_o !== 1'h0 && n < 20) begin
      n++;
      @(posedge clk_i);
    end
    chk({31'h0, waitrequest_o}, 32'h0);
    d = readdata_o;
    read_i <= 1'h0;
    write_i <= 1'h0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] d;
    bus(1'h1, a, v, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    bus(1'h0, a, 32'h0, d);
    chk(d, exp);
  endtask

  task automatic drive(input int k, input logic v);
    case (k)
      K_POR: por_i <= v;
      K_BOR: bor_i <= v;
      K_MASTER_CLEAR_PIN: master_clear_pin_n_i <= ~v;
      K_WDT: wdt_timeout_i <= v;
      K_RI: reset_instr_i <= v;
      K_OVF: stack_overflow_i <= v;
      K_UNF: stack_underflow_i <= v;
      default: int_wake_i <= v;
    endcase
  endtask

  // Pulses one event (the pin is held low for a while) and counts the
  // restart pulses that follow, keeping the last restart address.
  task automatic fire(input int k, input logic [1:0] pm);
    got_n = 0;
    got_pc = 21'h0;
    power_mode_i <= pm;
    drive(k, 1'h1);
    for (int n = 0; n < 8; n++) begin
      @(posedge clk_i);
      if (n == 0 && k != K_MASTER_CLEAR_PIN) drive(k, 1'h0);
      @(negedge clk_i);
      if (core_restart_o === 1'h1) begin
        got_n++;
        got_pc = restart_pc_o;
      end
    end
    @(posedge clk_i);
    if (k == K_MASTER_CLEAR_PIN) drive(k, 1'h0);
    repeat (3) @(posedge clk_i);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    srst_i = 1'h1; read_i = 1'h0; write_i = 1'h0; address_i = 8'h00;
    writedata_i = 32'h0; por_i = 1'h0; bor_i = 1'h0;
    master_clear_pin_n_i = 1'h1; wdt_timeout_i = 1'h0;
    reset_instr_i = 1'h0; stack_overflow_i = 1'h0;
    stack_underflow_i = 1'h0; int_wake_i = 1'h0; int_wake_high_i = 1'h0;
    int_wake_flags_i = WAKE_FLAGS; power_mode_i = PM_FULL;
    core_pc_i = CORE_PC; osc_frees_pins_i = 1'h0; port_a_pins_i = 8'hFF;
    rows = '{
      '{K_WDT, 2'h0, 1'h1, 21'h0, 8'h17, 8'h00},
      '{K_MASTER_CLEAR_PIN, 2'h1, 1'h1, 21'h0, 8'h1F, 8'h00},
      '{K_WDT, 2'h1, 1'h1, 21'h0, 8'h17, 8'h00},
      '{K_MASTER_CLEAR_PIN, 2'h0, 1'h1, 21'h0, 8'h17, 8'h00},
      '{K_MASTER_CLEAR_PIN, 2'h2, 1'h1, 21'h0, 8'h1B, 8'h00},
      '{K_RI, 2'h0, 1'h1, 21'h0, 8'h0B, 8'h00},
      '{K_OVF, 2'h0, 1'h1, 21'h0, 8'h0B, 8'h80},
      '{K_UNF, 2'h0, 1'h1, 21'h0, 8'h0B, 8'hC0},
      '{K_BOR, 2'h0, 1'h1, 21'h0, 8'h1E, 8'hC0},
      '{K_POR, 2'h0, 1'h1, 21'h0, 8'h1C, 8'h00},
      '{K_WDT, 2'h2, 1'h1, WAKE_PC, 8'h10, 8'h00},
      '{K_MASTER_CLEAR_PIN, 2'h1, 1'h1, 21'h0, 8'h18, 8'h00},
      '{K_BOR, 2'h0, 1'h1, 21'h0, 8'h1C, 8'h00},
      '{K_INT, 2'h1, 1'h1, WAKE_PC, 8'h18, 8'h00},
      '{K_INT, 2'h0, 1'h0, 21'h0, 8'h18, 8'h00}};
    repeat (10) @(posedge clk_i);
    srst_i <= 1'h0;
    @(posedge clk_i);
    rdc(REG_STATUS, 32'h1F);
    rdc(REG_STACK, 32'h0);
    rdc(REG_INTC, 32'h00C0F500);
    rdc(REG_CFG, 32'h3);
    $display("test reset_values done");
    wr(REG_STATUS, 32'hFF);
    rdc(REG_STATUS, 32'h9F);
    wr(REG_STATUS, 32'h0);
    rdc(REG_STATUS, 32'h0C);
    wr(8'h40, 32'hFFFFFFFF);
    rdc(8'h40, 32'h0);
    wr(REG_PC, 32'h1FFFFF);
    rdc(REG_PC, 32'h0);
    wr(REG_STATUS, 32'h13);
    rdc(REG_STATUS, 32'h1F);
    $display("test register_access done");
    foreach (rows[i]) begin
      fire(rows[i].k, rows[i].pm);
      chk(32'(got_n), {31'h0, rows[i].rst});
      if (rows[i].rst) chk({11'h0, got_pc}, {11'h0, rows[i].pc});
      rdc(REG_STATUS, {24'h0, rows[i].st});
      rdc(REG_STACK, {24'h0, rows[i].stk});
    end
    rdc(REG_INTC, {8'h0, INTC_C_RST, INTC_B_RST, WAKE_FLAGS});
    $display("test event_table done");
    wr(REG_CFG, 32'h2);
    fire(K_UNF, PM_FULL);
    chk(32'(got_n), 32'h0);
    rdc(REG_STATUS, 32'h18);
    rdc(REG_STACK, 32'h40);
    fire(K_OVF, PM_FULL);
    chk(32'(got_n), 32'h0);
    wr(REG_CFG, 32'h1);
    fire(K_MASTER_CLEAR_PIN, PM_RUN);
    chk(32'(got_n), 32'h0);
    wr(REG_CFG, 32'h3);
    $display("test stack_error done");
    wr(REG_INTC, 32'h00C0F580);
    int_wake_high_i <= 1'h1;
    fire(K_INT, PM_IDLE);
    chk({11'h0, got_pc}, {11'h0, VEC_HIGH});
    rdc(REG_TOS, {11'h0, CORE_PC});
    rdc(REG_STACK, 32'h41);
    wr(REG_INTC, 32'h00C0F540);
    int_wake_high_i <= 1'h0;
    fire(K_INT, PM_IDLE);
    chk({11'h0, got_pc}, {11'h0, VEC_LOW});
    rdc(REG_STACK, 32'h42);
    $display("test vectors done");
    wr(REG_PCLAT, 32'h1FFF);
    wr(REG_TBLPTR, 32'h3FFFFF);
    wr(REG_TBLAT, 32'hAA);
    wr(REG_PROD, 32'hBEEF);
    wr(REG_WORK, 32'hABC5A);
    fire(K_RI, PM_FULL);
    rdc(REG_PCLAT, 32'h0);
    rdc(REG_TBLPTR, 32'h0);
    rdc(REG_TBLAT, 32'h0);
    rdc(REG_TOS, 32'h0);
    rdc(REG_STACK, 32'h40);
    rdc(REG_INTC, 32'h00C0F500);
    rdc(REG_PROD, 32'hBEEF);
    rdc(REG_WORK, 32'hABC5A);
    wr(REG_PCLAT, 32'h1FFF);
    fire(K_WDT, PM_IDLE);
    rdc(REG_PCLAT, 32'h1FFF);
    rdc(REG_PC, {11'h0, WAKE_PC});
    $display("test core_registers done");
    wr(REG_PORT_A_PINS, 32'hFFFF);
    rdc(REG_PORT_A_PINS, 32'h003F3F3F);
    chk({24'h0, port_a_latch_o}, 32'h3F);
    chk({24'h0, port_a_direction_o}, 32'h3F);
    osc_frees_pins_i <= 1'h1;
    @(posedge clk_i);
    wr(REG_PORT_A_PINS, 32'hFFFF);
    rdc(REG_PORT_A_PINS, 32'h00FFFFFF);
    chk({24'h0, port_a_latch_o}, 32'hFF);
    $display("test port_a done");
    srst_i <= 1'h1;
    repeat (3) @(posedge clk_i);
    srst_i <= 1'h0;
    @(posedge clk_i);
    rdc(REG_STATUS, 32'h1F);
    rdc(REG_STACK, 32'h0);
    $display("test second_reset done");
    summarize();
  end
endmodule
